// ---- hw/mxe_alu.sv ----
// combinational data path for rotate, swap, bit and count operations
`default_nettype none
module mxe_alu (
  // operands
  input  wire mxe_pkg::mxe_op_t op,
  input  wire logic [7:0]       mem_val,
  input  wire logic [7:0]       acc_val,
  input  wire logic [7:0]       lit,
  input  wire logic [2:0]       bit_sel,
  input  wire logic             carry_in,
  // results
  output logic [7:0]            result,
  output logic                  carry_out,
  output logic                  bit_val
);
  wire [7:0] bit_mask = 8'h01 << bit_sel;
  wire [7:0] rr_val   = {mem_val[0], mem_val[7:1]};
  wire [7:0] rl_val   = {mem_val[6:0], mem_val[7]};
  wire [7:0] rrc_val  = {carry_in, mem_val[7:1]};
  wire [7:0] rlc_val  = {mem_val[6:0], carry_in};
  wire [7:0] inc_val  = 8'(mem_val + 8'h01);
  wire [7:0] dec_val  = 8'(mem_val - 8'h01);

  assign bit_val = |(mem_val & bit_mask);

  always_comb begin
    carry_out = carry_in;
    case (op)
      mxe_pkg::MXE_ROTATE_RIGHT:           result = rr_val;
      mxe_pkg::MXE_ROTATE_RIGHT_VIA_CARRY: begin
        result    = rrc_val;
        carry_out = mem_val[0];
      end
      mxe_pkg::MXE_ROTATE_LEFT:            result = rl_val;
      mxe_pkg::MXE_ROTATE_LEFT_VIA_CARRY:  begin
        result    = rlc_val;
        carry_out = mem_val[7];
      end
      mxe_pkg::MXE_COPY_ACC_TO_MEM:        result = acc_val;
      mxe_pkg::MXE_COPY_LIT_TO_ACC:        result = lit;
      mxe_pkg::MXE_BIT_CLEAR:              result = mem_val & ~bit_mask;
      mxe_pkg::MXE_BIT_SET:                result = mem_val | bit_mask;
      mxe_pkg::MXE_BYTE_CLEAR:             result = mxe_pkg::BYTE_ZERO;
      mxe_pkg::MXE_BYTE_SET:               result = mxe_pkg::BYTE_ONES;
      mxe_pkg::MXE_INCREMENT_SKIP_ZERO:    result = inc_val;
      mxe_pkg::MXE_DECREMENT_SKIP_ZERO:    result = dec_val;
      mxe_pkg::MXE_NIBBLE_EXCHANGE:        result = {mem_val[3:0], mem_val[7:4]};
      default:                             result = mem_val;
    endcase
  end
endmodule
`default_nettype wire

// ---- hw/mxe_core.sv ----
// execution and timing core for rotate, move, branch, skip, table and control instructions
`default_nettype none
module mxe_core (
  // clock and reset
  input  wire logic                         clk,
  input  wire logic                         rst,
  // instruction issue
  input  wire mxe_pkg::mxe_instr_t          instr,
  input  wire logic                         instr_valid,
  output logic                              instr_ready,
  // data memory
  input  wire logic [7:0]                   mem_rdata,
  output mxe_pkg::mxe_mem_wr_t              mem_wr,
  // program memory table port
  output logic [mxe_pkg::PC_W-1:0]          prog_addr,
  input  wire logic [13:0]                  prog_rdata,
  // state
  output logic [7:0]                        acc,
  output logic [mxe_pkg::PC_W-1:0]          pc,
  output logic [5:0]                        table_high_byte,
  output mxe_pkg::mxe_flags_t               flags,
  output logic                              watchdog_clear,
  output logic                              prescaler_clear,
  output logic                              halted,
  // wake from power down and watchdog timeout event
  input  wire logic                         wake,
  input  wire logic                         timeout_event
);
  typedef enum logic [1:0] {
    MXE_EXEC  = 2'b00,
    MXE_EXTRA = 2'b01,
    MXE_SLEEP = 2'b10
  } mxe_state_t;

  mxe_state_t                 st_q, st_d;
  logic [7:0]                 acc_q, acc_d;
  logic [mxe_pkg::PC_W-1:0]   pc_q, pc_d;
  logic [5:0]                 tbh_q, tbh_d;
  mxe_pkg::mxe_flags_t        fl_q, fl_d;
  logic                       pre1_q, pre1_d;
  logic                       pre2_q, pre2_d;
  logic [mxe_pkg::PC_W-1:0]   stack_q [mxe_pkg::STACK_N];
  logic                       sp_q;
  mxe_pkg::mxe_instr_t        held_q;
  logic [7:0]                 held_mem_q;

  logic [7:0] alu_res;
  logic       alu_carry;
  logic       alu_bit;

  mxe_alu u_alu (
    .op        (instr.op),
    .mem_val   (mem_rdata),
    .acc_val   (acc_q),
    .lit       (instr.lit),
    .bit_sel   (instr.bit_sel),
    .carry_in  (fl_q.carry),
    .result    (alu_res),
    .carry_out (alu_carry),
    .bit_val   (alu_bit)
  );

  // decode
  wire exec     = (st_q == MXE_EXEC) && instr_valid;
  wire op_skipz = instr.op == mxe_pkg::MXE_SKIP_ON_ZERO;
  wire op_inc   = instr.op == mxe_pkg::MXE_INCREMENT_SKIP_ZERO;
  wire op_dec   = instr.op == mxe_pkg::MXE_DECREMENT_SKIP_ZERO;
  wire op_bitz  = instr.op == mxe_pkg::MXE_SKIP_ON_ZERO_BIT;
  wire op_bitnz = instr.op == mxe_pkg::MXE_SKIP_ON_NONZERO_BIT;
  wire op_table = instr.op == mxe_pkg::MXE_TABLE_READ_CURRENT ||
                  instr.op == mxe_pkg::MXE_TABLE_READ_LAST;
  wire op_rot   = instr.op inside {mxe_pkg::MXE_ROTATE_RIGHT, mxe_pkg::MXE_ROTATE_RIGHT_VIA_CARRY,
                                   mxe_pkg::MXE_ROTATE_LEFT, mxe_pkg::MXE_ROTATE_LEFT_VIA_CARRY,
                                   mxe_pkg::MXE_NIBBLE_EXCHANGE};
  wire op_rotc  = instr.op inside {mxe_pkg::MXE_ROTATE_RIGHT_VIA_CARRY,
                                   mxe_pkg::MXE_ROTATE_LEFT_VIA_CARRY};
  wire op_mwr   = instr.op inside {mxe_pkg::MXE_COPY_ACC_TO_MEM, mxe_pkg::MXE_BIT_CLEAR,
                                   mxe_pkg::MXE_BIT_SET, mxe_pkg::MXE_BYTE_CLEAR,
                                   mxe_pkg::MXE_BYTE_SET};
  wire op_branch = instr.op inside {mxe_pkg::MXE_UNCONDITIONAL_JUMP, mxe_pkg::MXE_CALL,
                                    mxe_pkg::MXE_SUBROUTINE_EXIT, mxe_pkg::MXE_SUBROUTINE_EXIT_LIT,
                                    mxe_pkg::MXE_INTERRUPT_EXIT};
  wire op_pre1  = instr.op == mxe_pkg::MXE_WATCHDOG_PRECLEAR_1;
  wire op_pre2  = instr.op == mxe_pkg::MXE_WATCHDOG_PRECLEAR_2;

  // skip conditions
  wire skip_hit = (op_skipz && mem_rdata == mxe_pkg::BYTE_ZERO) ||
                  ((op_inc || op_dec) && alu_res == mxe_pkg::BYTE_ZERO) ||
                  (op_bitz && !alu_bit) ||
                  (op_bitnz && alu_bit);

  // memory-destination write of the counter low byte
  wire mem_dest = (op_rot && !instr.to_acc) || ((op_inc || op_dec) && !instr.to_acc) || op_mwr;
  wire pcl_hit  = exec && mem_dest && ({2'b00, instr.addr} == mxe_pkg::PCL_ADDR);
  wire two_cyc  = exec && (skip_hit || op_branch || op_table || pcl_hit);

  wire [mxe_pkg::PC_W-1:0] pc_inc    = mxe_pkg::PC_W'(pc_q + 1'b1);
  wire [mxe_pkg::PC_W-1:0] page_base = (held_q.op == mxe_pkg::MXE_TABLE_READ_LAST) ?
                                       mxe_pkg::LAST_PAGE :
                                       {pc_q[mxe_pkg::PC_W-1:mxe_pkg::PAGE_W], mxe_pkg::PAGE_W'(0)};
  wire in_extra = st_q == MXE_EXTRA;
  wire tbl_fin  = in_extra && (held_q.op == mxe_pkg::MXE_TABLE_READ_CURRENT ||
                               held_q.op == mxe_pkg::MXE_TABLE_READ_LAST);

  assign instr_ready = st_q == MXE_EXEC;
  assign prog_addr   = page_base | {2'b00, held_mem_q};
  assign acc         = acc_q;
  assign pc          = pc_q;
  assign table_high_byte = tbh_q;
  assign flags       = fl_q;
  assign halted      = st_q == MXE_SLEEP;

  always_comb begin
    st_d   = st_q;
    acc_d  = acc_q;
    pc_d   = pc_q;
    tbh_d  = tbh_q;
    fl_d   = fl_q;
    pre1_d = pre1_q;
    pre2_d = pre2_q;
    mem_wr = '0;
    watchdog_clear  = 1'b0;
    prescaler_clear = 1'b0;
    if (timeout_event) begin
      fl_d.timeout_flag = 1'b1;
    end
    case (st_q)
      MXE_EXEC: begin
        if (instr_valid) begin
          pc_d = pc_inc;
          if (two_cyc) begin
            st_d = MXE_EXTRA;
          end
          if (op_rotc) begin
            fl_d.carry = alu_carry;
          end
          if ((op_rot || op_inc || op_dec) && instr.to_acc) begin
            acc_d = alu_res;
          end
          if (mem_dest) begin
            mem_wr = '{en: 1'b1, addr: instr.addr, data: alu_res};
          end
          if (op_skipz && instr.to_acc) begin
            acc_d = mem_rdata;
          end
          case (instr.op)
            mxe_pkg::MXE_COPY_MEM_TO_ACC: acc_d = mem_rdata;
            mxe_pkg::MXE_COPY_LIT_TO_ACC: acc_d = instr.lit;
            mxe_pkg::MXE_UNCONDITIONAL_JUMP: pc_d = instr.target;
            mxe_pkg::MXE_CALL: pc_d = instr.target;
            mxe_pkg::MXE_SUBROUTINE_EXIT,
            mxe_pkg::MXE_INTERRUPT_EXIT: pc_d = stack_q[sp_q - 1'b1];
            mxe_pkg::MXE_SUBROUTINE_EXIT_LIT: begin
              pc_d  = stack_q[sp_q - 1'b1];
              acc_d = instr.lit;
            end
            mxe_pkg::MXE_WATCHDOG_CLEAR: begin
              fl_d.timeout_flag = 1'b0;
              fl_d.sleep_flag   = 1'b0;
              watchdog_clear    = 1'b1;
              pre1_d = 1'b0;
              pre2_d = 1'b0;
            end
            mxe_pkg::MXE_POWER_DOWN: begin
              fl_d.timeout_flag = 1'b0;
              fl_d.sleep_flag   = 1'b1;
              watchdog_clear    = 1'b1;
              prescaler_clear   = 1'b1;
              st_d = MXE_SLEEP;
            end
            default: ;
          endcase
          // pair must alternate; a repeat of one half has no effect
          if (op_pre1) begin
            if (pre2_q) begin
              fl_d.timeout_flag = 1'b0;
              fl_d.sleep_flag   = 1'b0;
              watchdog_clear    = 1'b1;
              pre2_d = 1'b0;
            end else begin
              pre1_d = 1'b1;
            end
          end else if (op_pre2) begin
            if (pre1_q) begin
              fl_d.timeout_flag = 1'b0;
              fl_d.sleep_flag   = 1'b0;
              watchdog_clear    = 1'b1;
              pre1_d = 1'b0;
            end else begin
              pre2_d = 1'b1;
            end
          end else begin
            pre1_d = 1'b0;
            pre2_d = 1'b0;
          end
          if (pcl_hit) begin
            pc_d = {pc_q[mxe_pkg::PC_W-1:8], alu_res};
          end
        end
      end
      MXE_EXTRA: begin
        st_d = MXE_EXEC;
        if (tbl_fin) begin
          tbh_d  = prog_rdata[13:8];
          mem_wr = '{en: 1'b1, addr: held_q.addr, data: prog_rdata[7:0]};
        end
      end
      MXE_SLEEP: begin
        if (wake) begin
          st_d = MXE_EXEC;
        end
      end
      default: st_d = MXE_EXEC;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q   <= MXE_EXEC;
      acc_q  <= mxe_pkg::BYTE_ZERO;
      pc_q   <= mxe_pkg::PC_RESET;
      tbh_q  <= '0;
      fl_q   <= '0;
      pre1_q <= 1'b0;
      pre2_q <= 1'b0;
    end else begin
      st_q   <= st_d;
      acc_q  <= acc_d;
      pc_q   <= pc_d;
      tbh_q  <= tbh_d;
      fl_q   <= fl_d;
      pre1_q <= pre1_d;
      pre2_q <= pre2_d;
    end
  end

  // return stack and held operand for the second cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      sp_q       <= 1'b0;
      held_q     <= '0;
      held_mem_q <= mxe_pkg::BYTE_ZERO;
      for (int i = 0; i < mxe_pkg::STACK_N; i++) begin
        stack_q[i] <= mxe_pkg::PC_RESET;
      end
    end else if (exec) begin
      held_q     <= instr;
      held_mem_q <= mem_rdata;
      if (instr.op == mxe_pkg::MXE_CALL) begin
        stack_q[sp_q] <= pc_inc;
        sp_q          <= sp_q + 1'b1;
      end else if (instr.op inside {mxe_pkg::MXE_SUBROUTINE_EXIT, mxe_pkg::MXE_SUBROUTINE_EXIT_LIT,
                                    mxe_pkg::MXE_INTERRUPT_EXIT}) begin
        sp_q <= sp_q - 1'b1;
      end
    end
  end

  // assertions
  sequence s_two_cycle_issue;
    exec && two_cyc ##1 !instr_ready;
  endsequence

  property p_branch_two;
    @(posedge clk) disable iff (rst) exec && op_branch |=> !instr_ready ##1 instr_ready;
  endproperty
  a_branch_two: assert property (p_branch_two) else $error("branch not two cycles");

  property p_skip_two;
    @(posedge clk) disable iff (rst) exec && skip_hit |-> s_two_cycle_issue;
  endproperty
  a_skip_two: assert property (p_skip_two) else $error("skip not two cycles");

  property p_noskip_one;
    @(posedge clk) disable iff (rst)
      exec && (op_skipz || op_bitz || op_bitnz) && !skip_hit && !pcl_hit |=> instr_ready;
  endproperty
  a_noskip_one: assert property (p_noskip_one) else $error("no-skip not one cycle");

  property p_carry_kept;
    @(posedge clk) disable iff (rst) exec && !op_rotc && !timeout_event |=> $stable(flags.carry);
  endproperty
  a_carry_kept: assert property (p_carry_kept) else $error("carry changed");

  property p_rrc_carry;
    @(posedge clk) disable iff (rst)
      exec && instr.op == mxe_pkg::MXE_ROTATE_RIGHT_VIA_CARRY |=> flags.carry == $past(mem_rdata[0]);
  endproperty
  a_rrc_carry: assert property (p_rrc_carry) else $error("rotate carry wrong");

  property p_sleep;
    @(posedge clk) disable iff (rst)
      exec && instr.op == mxe_pkg::MXE_POWER_DOWN |=> halted && flags.sleep_flag;
  endproperty
  a_sleep: assert property (p_sleep) else $error("power down failed");

  property p_pair;
    @(posedge clk) disable iff (rst)
      exec && op_pre2 && pre1_q && !timeout_event |=> !flags.timeout_flag && !flags.sleep_flag;
  endproperty
  a_pair: assert property (p_pair) else $error("preclear pair failed");

  property p_single_pre;
    @(posedge clk) disable iff (rst)
      exec && op_pre1 && !pre2_q |=> $stable(flags.sleep_flag);
  endproperty
  a_single_pre: assert property (p_single_pre) else $error("single preclear acted");

  property p_table;
    @(posedge clk) disable iff (rst) exec && op_table |=> mem_wr.en ##1 instr_ready;
  endproperty
  a_table: assert property (p_table) else $error("table read timing");

  sequence s_stall_then_ready;
    !instr_ready ##1 instr_ready;
  endsequence

  property p_pcl_two;
    @(posedge clk) disable iff (rst) exec && pcl_hit |=> s_stall_then_ready;
  endproperty
  a_pcl_two: assert property (p_pcl_two) else $error("counter low write not two cycles");

  property p_call_target;
    @(posedge clk) disable iff (rst)
      exec && instr.op == mxe_pkg::MXE_CALL |=> pc == $past(instr.target);
  endproperty
  a_call_target: assert property (p_call_target) else $error("call target not loaded");

  property p_wdt_clear;
    @(posedge clk) disable iff (rst)
      exec && instr.op == mxe_pkg::MXE_WATCHDOG_CLEAR |->
        watchdog_clear ##1 !flags.timeout_flag && !flags.sleep_flag;
  endproperty
  a_wdt_clear: assert property (p_wdt_clear) else $error("watchdog clear failed");

  property p_table_high;
    @(posedge clk) disable iff (rst) tbl_fin |=> table_high_byte == $past(prog_rdata[13:8]);
  endproperty
  a_table_high: assert property (p_table_high) else $error("table high byte wrong");

  property p_move_flags;
    @(posedge clk) disable iff (rst)
      exec && instr.op inside {mxe_pkg::MXE_COPY_MEM_TO_ACC, mxe_pkg::MXE_COPY_ACC_TO_MEM,
                               mxe_pkg::MXE_COPY_LIT_TO_ACC} && !timeout_event |=> $stable(flags);
  endproperty
  a_move_flags: assert property (p_move_flags) else $error("move changed flags");

  property p_halt_hold;
    @(posedge clk) disable iff (rst) halted && !wake |=> halted && !instr_ready;
  endproperty
  a_halt_hold: assert property (p_halt_hold) else $error("power down left early");
endmodule
`default_nettype wire

// ---- hw/mxe_pkg.sv ----
// shared types and constants for the instruction execution block
// Behaviour
// - plain right rotate, one cycle, no flags
// - right rotate through carry, updates carry only
// - plain left rotate, one cycle, no flags
// - left rotate through carry, updates carry only
// - moves take one cycle, no flags
// - bit and byte set/clear, one cycle
// - jump, call, returns take two cycles
// - skip if byte zero, optional accumulator load
// - skip on selected bit zero or nonzero
// - increment/decrement and skip when result zero
// - skip taken costs two cycles, else one
// - writing counter low byte costs two cycles
// - table read two cycles, high to table register
// - nibble swap one cycle, in place or accumulator
// - power down one cycle, touches timeout/sleep flags
// - preclear pair clears flags only when consecutive
// - power down halts, clears watchdog, sets sleep
// - single watchdog clear clears both flags
// - call pushes return address, loads target
`default_nettype none
package mxe_pkg;
  localparam int PC_W = 10;
  localparam int DA_W = 6;
  localparam logic [PC_W-1:0] PC_RESET = 10'h000;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_ONES = 8'hff;
  localparam logic [7:0] PCL_ADDR  = 8'h06;
  localparam logic [PC_W-1:0] LAST_PAGE = 10'h300;
  localparam int PAGE_W = 8;
  localparam int STACK_N = 2;

  typedef enum logic [4:0] {
    MXE_NO_OPERATION           = 5'h00,
    MXE_ROTATE_RIGHT           = 5'h01,
    MXE_ROTATE_RIGHT_VIA_CARRY = 5'h02,
    MXE_ROTATE_LEFT            = 5'h03,
    MXE_ROTATE_LEFT_VIA_CARRY  = 5'h04,
    MXE_COPY_MEM_TO_ACC        = 5'h05,
    MXE_COPY_ACC_TO_MEM        = 5'h06,
    MXE_COPY_LIT_TO_ACC        = 5'h07,
    MXE_BIT_CLEAR              = 5'h08,
    MXE_BIT_SET                = 5'h09,
    MXE_BYTE_CLEAR             = 5'h0a,
    MXE_BYTE_SET               = 5'h0b,
    MXE_UNCONDITIONAL_JUMP     = 5'h0c,
    MXE_CALL                   = 5'h0d,
    MXE_SUBROUTINE_EXIT        = 5'h0e,
    MXE_SUBROUTINE_EXIT_LIT    = 5'h0f,
    MXE_INTERRUPT_EXIT         = 5'h10,
    MXE_SKIP_ON_ZERO           = 5'h11,
    MXE_SKIP_ON_ZERO_BIT       = 5'h12,
    MXE_SKIP_ON_NONZERO_BIT    = 5'h13,
    MXE_INCREMENT_SKIP_ZERO    = 5'h14,
    MXE_DECREMENT_SKIP_ZERO    = 5'h15,
    MXE_TABLE_READ_CURRENT     = 5'h16,
    MXE_TABLE_READ_LAST        = 5'h17,
    MXE_NIBBLE_EXCHANGE        = 5'h18,
    MXE_WATCHDOG_CLEAR         = 5'h19,
    MXE_WATCHDOG_PRECLEAR_1    = 5'h1a,
    MXE_WATCHDOG_PRECLEAR_2    = 5'h1b,
    MXE_POWER_DOWN             = 5'h1c
  } mxe_op_t;

  // decoded instruction presented by the fetch stage
  typedef struct packed {
    mxe_op_t         op;
    logic            to_acc;
    logic [2:0]      bit_sel;
    logic [DA_W-1:0] addr;
    logic [7:0]      lit;
    logic [PC_W-1:0] target;
  } mxe_instr_t;

  // data memory write request
  typedef struct packed {
    logic            en;
    logic [DA_W-1:0] addr;
    logic [7:0]      data;
  } mxe_mem_wr_t;

  typedef struct packed {
    logic timeout_flag;
    logic sleep_flag;
    logic carry;
  } mxe_flags_t;
endpackage
`default_nettype wire

// ---- test/mxe_core_tb.sv ----
// self-checking bench for the execution core
`default_nettype none
module mxe_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                 clk, rst, instr_valid, instr_ready, wake, timeout_event;
  logic                 watchdog_clear, prescaler_clear, halted, cy;
  logic [7:0]           mem_rdata, acc;
  logic [9:0]           prog_addr, pc, pa;
  logic [13:0]          prog_rdata;
  logic [5:0]           table_high_byte;
  mxe_pkg::mxe_instr_t  instr;
  mxe_pkg::mxe_mem_wr_t mem_wr;
  mxe_pkg::mxe_flags_t  flags;
  int                   fails = 0, cmp_count = 0, cyc;
  mxe_core u_mxe_core (.clk(clk), .rst(rst), .instr(instr), .instr_valid(instr_valid),
    .instr_ready(instr_ready), .mem_rdata(mem_rdata), .mem_wr(mem_wr), .prog_addr(prog_addr),
    .prog_rdata(prog_rdata), .acc(acc), .pc(pc), .table_high_byte(table_high_byte),
    .flags(flags), .watchdog_clear(watchdog_clear), .prescaler_clear(prescaler_clear),
    .halted(halted), .wake(wake), .timeout_event(timeout_event));
  mxe_mem_model u_mxe_mem_model (.clk(clk), .rd_addr(instr.addr), .rdata(mem_rdata),
    .wr(mem_wr), .prog_addr(prog_addr), .prog_rdata(prog_rdata));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic results();
    if (fails == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic mchk(input logic [5:0] a, input logic [7:0] e);
    chk("mem", 32'(e), 32'(u_mxe_mem_model.dmem[a]));
  endtask
  task automatic achk(input logic [7:0] e);
    chk("acc", 32'(e), 32'(acc));
  endtask
  task automatic fchk(input logic t, input logic s);
    chk("flags", 32'({t, s, cy}), 32'(flags));
  endtask
  // issue one instruction and count cycles until ready returns
  task automatic ex(input mxe_pkg::mxe_op_t op, input logic ta, input logic [5:0] a,
                    input logic [9:0] v, input int ec);
    instr = '{op, ta, v[2:0], a, v[7:0], v};
    instr_valid = 1'b1;
    @(negedge clk);
    instr_valid = 1'b0;
    cyc = 1;
    while (instr_ready !== 1'b1 && cyc < 40) begin
      pa = prog_addr;
      @(negedge clk);
      cyc++;
    end
    // idle cycle so valid never toggles twice in one step
    @(negedge clk);
    chk("cycles", 32'(ec), 32'(cyc));
    if (cyc >= 40) results();
  endtask
  task automatic sk(input mxe_pkg::mxe_op_t op, input logic ta, input logic [7:0] m,
                    input logic [2:0] b, input int ec);
    u_mxe_mem_model.dmem[7] = m;
    ex(op, ta, 6'h7, 10'(b), ec);
  endtask
  task automatic tpulse();
    timeout_event = 1'b1;
    @(negedge clk);
    timeout_event = 1'b0;
  endtask
  task automatic t_rotate();
    logic [7:0] m, e;
    logic       nc;
    for (int i = 0; i < 8; i++) begin
      m = i[0] ? 8'h42 : 8'h81;
      nc = cy;
      case (i / 2)
        0: e = {m[0], m[7:1]};
        1: {e, nc} = {cy, m};
        2: e = {m[6:0], m[7]};
        default: {nc, e} = {m, cy};
      endcase
      u_mxe_mem_model.dmem[1] = m;
      ex(mxe_pkg::mxe_op_t'(5'h01 + 5'(i / 2)), i[0], 6'h1, 10'h0, 1);
      mchk(6'h1, i[0] ? m : e);
      if (i[0]) achk(e);
      cy = nc;
      fchk(1'b0, 1'b0);
    end
  endtask
  task automatic t_move();
    u_mxe_mem_model.dmem[3] = 8'h5a;
    ex(mxe_pkg::MXE_COPY_LIT_TO_ACC, 1'b1, 6'h0, 10'h0a5, 1);
    achk(8'ha5);
    ex(mxe_pkg::MXE_COPY_ACC_TO_MEM, 1'b0, 6'h4, 10'h0, 1);
    mchk(6'h4, 8'ha5);
    ex(mxe_pkg::MXE_COPY_MEM_TO_ACC, 1'b1, 6'h3, 10'h0, 1);
    achk(8'h5a);
    ex(mxe_pkg::MXE_BIT_SET, 1'b0, 6'h3, 10'h0, 1);
    ex(mxe_pkg::MXE_BIT_CLEAR, 1'b0, 6'h3, 10'h6, 1);
    mchk(6'h3, 8'h1b);
    ex(mxe_pkg::MXE_BYTE_SET, 1'b0, 6'h4, 10'h0, 1);
    mchk(6'h4, 8'hff);
    ex(mxe_pkg::MXE_BYTE_CLEAR, 1'b0, 6'h4, 10'h0, 1);
    mchk(6'h4, 8'h00);
    ex(mxe_pkg::MXE_NIBBLE_EXCHANGE, 1'b0, 6'h3, 10'h0, 1);
    mchk(6'h3, 8'hb1);
    ex(mxe_pkg::MXE_NIBBLE_EXCHANGE, 1'b1, 6'h3, 10'h0, 1);
    achk(8'h1b);
    mchk(6'h3, 8'hb1);
    fchk(1'b0, 1'b0);
  endtask
  task automatic t_branch();
    ex(mxe_pkg::MXE_UNCONDITIONAL_JUMP, 1'b0, 6'h0, 10'h040, 2);
    chk("pc", 32'h040, 32'(pc));
    ex(mxe_pkg::MXE_CALL, 1'b0, 6'h0, 10'h123, 2);
    ex(mxe_pkg::MXE_CALL, 1'b0, 6'h0, 10'h150, 2);
    chk("pc", 32'h150, 32'(pc));
    ex(mxe_pkg::MXE_SUBROUTINE_EXIT, 1'b0, 6'h0, 10'h0, 2);
    chk("pc", 32'h124, 32'(pc));
    ex(mxe_pkg::MXE_SUBROUTINE_EXIT_LIT, 1'b1, 6'h0, 10'h03c, 2);
    chk("pc", 32'h041, 32'(pc));
    achk(8'h3c);
    ex(mxe_pkg::MXE_CALL, 1'b0, 6'h0, 10'h300, 2);
    ex(mxe_pkg::MXE_INTERRUPT_EXIT, 1'b0, 6'h0, 10'h0, 2);
    ex(mxe_pkg::MXE_NO_OPERATION, 1'b0, 6'h0, 10'h0, 1);
    chk("pc", 32'h043, 32'(pc));
    ex(mxe_pkg::MXE_COPY_ACC_TO_MEM, 1'b0, mxe_pkg::PCL_ADDR[5:0], 10'h0, 2);
    chk("pc", 32'h03c, 32'(pc));
    fchk(1'b0, 1'b0);
  endtask
  task automatic t_skip();
    sk(mxe_pkg::MXE_SKIP_ON_ZERO, 1'b1, 8'h00, 3'h0, 2);
    achk(8'h00);
    sk(mxe_pkg::MXE_SKIP_ON_ZERO, 1'b1, 8'h10, 3'h0, 1);
    achk(8'h10);
    sk(mxe_pkg::MXE_SKIP_ON_ZERO_BIT, 1'b0, 8'h10, 3'h4, 1);
    sk(mxe_pkg::MXE_SKIP_ON_ZERO_BIT, 1'b0, 8'h10, 3'h3, 2);
    sk(mxe_pkg::MXE_SKIP_ON_NONZERO_BIT, 1'b0, 8'h10, 3'h4, 2);
    sk(mxe_pkg::MXE_SKIP_ON_NONZERO_BIT, 1'b0, 8'h10, 3'h3, 1);
    sk(mxe_pkg::MXE_INCREMENT_SKIP_ZERO, 1'b0, 8'hff, 3'h0, 2);
    mchk(6'h7, 8'h00);
    sk(mxe_pkg::MXE_INCREMENT_SKIP_ZERO, 1'b1, 8'h10, 3'h0, 1);
    achk(8'h11);
    mchk(6'h7, 8'h10);
    sk(mxe_pkg::MXE_DECREMENT_SKIP_ZERO, 1'b0, 8'h01, 3'h0, 2);
    mchk(6'h7, 8'h00);
    sk(mxe_pkg::MXE_DECREMENT_SKIP_ZERO, 1'b1, 8'h01, 3'h0, 2);
    achk(8'h00);
    mchk(6'h7, 8'h01);
    fchk(1'b0, 1'b0);
  endtask
  task automatic tchk(input logic [9:0] ea);
    chk("paddr", 32'(ea), 32'(pa));
    mchk(6'h9, ea[7:0] ^ 8'h5a);
    chk("tbh", 32'(ea[5:0] ^ 6'h15), 32'(table_high_byte));
  endtask
  task automatic t_table();
    u_mxe_mem_model.dmem[9] = 8'h77;
    ex(mxe_pkg::MXE_UNCONDITIONAL_JUMP, 1'b0, 6'h0, 10'h1a0, 2);
    ex(mxe_pkg::MXE_TABLE_READ_CURRENT, 1'b0, 6'h9, 10'h0, 2);
    tchk(10'h177);
    ex(mxe_pkg::MXE_TABLE_READ_LAST, 1'b0, 6'h9, 10'h0, 2);
    tchk(10'h32d);
    fchk(1'b0, 1'b0);
  endtask
  task automatic t_wdt();
    int n;
    tpulse();
    instr = '{mxe_pkg::MXE_POWER_DOWN, 1'b0, 3'h0, 6'h0, 8'h0, 10'h0};
    instr_valid = 1'b1;
    #1;
    chk("wdt_psc", 32'h3, 32'({watchdog_clear, prescaler_clear}));
    @(negedge clk);
    instr_valid = 1'b0;
    repeat (3) @(negedge clk);
    chk("halt", 32'h2, 32'({halted, instr_ready}));
    fchk(1'b0, 1'b1);
    wake = 1'b1;
    @(negedge clk);
    wake = 1'b0;
    for (n = 0; n < 20 && instr_ready !== 1'b1; n++) @(negedge clk);
    chk("wake", 32'h0, 32'({halted, n == 20}));
    if (n == 20) results();
    tpulse();
    ex(mxe_pkg::MXE_WATCHDOG_PRECLEAR_1, 1'b0, 6'h0, 10'h0, 1);
    ex(mxe_pkg::MXE_NO_OPERATION, 1'b0, 6'h0, 10'h0, 1);
    ex(mxe_pkg::MXE_WATCHDOG_PRECLEAR_2, 1'b0, 6'h0, 10'h0, 1);
    ex(mxe_pkg::MXE_WATCHDOG_PRECLEAR_2, 1'b0, 6'h0, 10'h0, 1);
    fchk(1'b1, 1'b1);
    ex(mxe_pkg::MXE_WATCHDOG_PRECLEAR_1, 1'b0, 6'h0, 10'h0, 1);
    fchk(1'b0, 1'b0);
    tpulse();
    ex(mxe_pkg::MXE_WATCHDOG_CLEAR, 1'b0, 6'h0, 10'h0, 1);
    fchk(1'b0, 1'b0);
  endtask
  initial begin
    {rst, instr_valid, wake, timeout_event} = 4'h8;
    instr = '0;
    cy = 1'b0;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    chk("reset", 32'h1, 32'({acc, pc, flags, halted, instr_ready}));
    t_rotate();
    t_move();
    t_branch();
    t_skip();
    t_table();
    t_wdt();
    results();
  end
endmodule
`default_nettype wire

// ---- test/mxe_mem_model.sv ----
// data and program memory model facing the execution core
`default_nettype none
module mxe_mem_model (
  // clock
  input  wire logic                     clk,
  // data memory
  input  wire logic [mxe_pkg::DA_W-1:0] rd_addr,
  output logic [7:0]                    rdata,
  input  wire mxe_pkg::mxe_mem_wr_t     wr,
  // program memory
  input  wire logic [mxe_pkg::PC_W-1:0] prog_addr,
  output logic [13:0]                   prog_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] dmem [64];
  assign rdata = dmem[rd_addr];
  // word pattern follows its address
  assign prog_rdata = {prog_addr[5:0] ^ 6'h15, prog_addr[7:0] ^ 8'h5a};
  always @(posedge clk) begin
    if (wr.en) dmem[wr.addr] <= wr.data;
  end
endmodule
`default_nettype wire
